// ### rtl/dllrf_pkg.sv
// Shared constants for the DLL relock, clock change and write-leveling block.
// Assumes a 32-bit APB register bus and a seven-entry mode register set.
package dllrf_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_MRW = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MR_BASE = 8'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode register set
    localparam int MR_W = 18;
    localparam int MR_COUNT = 7;
    localparam logic [MR_W-1:0] MR_RESET = 18'h00000;
    localparam int MR_SEL_LSB = 18;
    localparam logic [2:0] MR_LATENCY = 3'h0;
    localparam logic [2:0] MR_DLL_TERM = 3'h1;
    localparam logic [2:0] MR_DATA_RATE = 3'h6;

    // Field positions in the mode registers
    localparam int DLL_EN_BIT = 0;
    localparam int DLL_RST_BIT = 8;
    localparam int LVL_EN_BIT = 7;
    localparam int QOFF_BIT = 12;

    // Command register bits
    localparam int CMD_SRE_BIT = 0;
    localparam int CMD_SRX_BIT = 1;

    // Status register bits
    localparam int ST_IN_SR_BIT = 0;
    localparam int ST_CK_IGN_BIT = 1;
    localparam int ST_DLL_EN_BIT = 2;
    localparam int ST_LOCKED_BIT = 3;
    localparam int ST_LVL_BIT = 4;
    localparam int ST_PEND_BIT = 5;

    // Default counts, in link clock rising edges
    localparam int DLL_LOCK_NCK_DEF = 768;
    localparam int SRE_HOLD_NCK_DEF = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // Self refresh state, Gray coded along idle, hold, ignore
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SR_HOLD = 2'b01,
        ST_SR_IGN = 2'b11
    } dllrf_sr_t;

endpackage

// ### rtl/dllrf_lane.sv
// One byte lane of write-leveling feedback.
// Assumes ck_level is already synchronised to clk; the strobe pin is not.
`timescale 1ns/1ps
`default_nettype none

module dllrf_lane
    import dllrf_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ck_level_in,
    input wire logic dqs_pin_in,
    output logic fb_out
);

    logic [1:0] dqs_sync;
    logic dqs_q;
    logic dqs_rise;

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe synchroniser and edge history
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dqs_sync <= 2'h0;
            dqs_q <= 1'b0;
        end else begin
            dqs_sync <= {dqs_sync[0], dqs_pin_in};
            dqs_q <= dqs_sync[1];
        end
    end

    assign dqs_rise = dqs_sync[1] & ~dqs_q;

    // Clock level caught on each strobe rising edge
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fb_out <= 1'b0;
        end else if (dqs_rise) begin
            fb_out <= ck_level_in; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    lane_sample_a: assert property (dqs_rise |=> fb_out == $past(ck_level_in)) // R16
        else $error("lane feedback does not hold sampled clock");
    lane_hold_a: assert property (!dqs_rise |=> $stable(fb_out)) // R20
        else $error("lane feedback changed without strobe edge");
    lane_rise_c: cover property (dqs_rise && ck_level_in);

endmodule

`default_nettype wire

// ### rtl/dllrf_top.sv
// DRAM side of DLL relock, clock frequency change and write-leveling feedback.
// Assumes an APB master on CLK_SYS_IN; CK and DQS pins arrive asynchronously.
//
// Operation
// R1: Controller starts from idle, nominal termination off, before self refresh entry.
// R2: After entry and clock hold, device ignores clock; controller may change it.
// R3: Controller gives stable new clock for exit setup time before exit.
// R4: Controller keeps clock enable high from exit until DLL lock time.
// R5: Controller holds termination pin constant until lock if termination was enabled.
// R6: After exit delay, controller writes DLL enable bit in DLL mode register.
// R7: After command delay, controller sets latency register reset bit to start relock.
// R8: Controller reprograms latencies; long calibration allowed after mode-update delay.
// R9: Controller waits mode update, lock time and calibration time before use.
// R10: Controller changes clock frequency only while device is in self refresh.
// R11: Controller disables parity latency before entry, re-enables after exit.
// R12: Clock-dependent settings updated after speed-up finish before leaving idle.
// R13: Data rate written before entry relocks at exit; after entry needs reset.
// R14: Controller keeps new frequency within speed grade limits.
// R15: Controller rewrites latencies, preambles and data rate for the new frequency.
// R16: In leveling, device samples clock on strobe rise and drives it back.
// R17: Controller steps strobe delay until feedback goes 0 to 1.
// R18: Device terminates strobe during leveling; controller terminates data bus.
// R19: Device drives leveling feedback on every data bit.
// R20: Each byte lane levels separately from its own strobe.
// R21: Controller issues many leveling bursts while varying strobe delay.
// R22: DLL disabled when DLL register bit 0 is 0, enabled when 1.
// R23: Leveling active while DLL register bit 7 is high.
// R24: Controller disables write termination before entering leveling.
// R25: Controller runs a separate countdown for each mandated wait.
`timescale 1ns/1ps
`default_nettype none

module dllrf_top
    import dllrf_pkg::*;
#(
    parameter int LANES = 2,
    parameter int LANE_BITS = 8,
    parameter int DLL_LOCK_NCK = DLL_LOCK_NCK_DEF,
    parameter int SRE_HOLD_NCK = SRE_HOLD_NCK_DEF
) (
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic CK_IN,
    input wire logic [LANES-1:0] DQS_IN,
    output logic [LANES*LANE_BITS-1:0] DQ_OUT,
    output logic [LANES*LANE_BITS-1:0] DQ_OE_N_OUT,
    output logic DQS_TERM_OUT
);

    localparam int HOLD_W = $clog2(SRE_HOLD_NCK + 1);
    localparam int LOCK_W = $clog2(DLL_LOCK_NCK + 1);

    if (LANES < 1 || LANES > 2 || LANE_BITS < 1 || DLL_LOCK_NCK < 1 || SRE_HOLD_NCK < 1) begin : g_chk
        $error("dllrf_top: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic is_mr_addr(input logic [ADDR_W-1:0] a);
        is_mr_addr = (a >= OFF_MR_BASE) && (a < OFF_MR_BASE + 8'(4 * MR_COUNT)) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] mr_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - OFF_MR_BASE;
        mr_index = d[4:2];
    endfunction

    logic [1:0] ck_sync;
    logic ck_q;
    logic ck_rise;
    logic access;
    logic wr_fire;
    logic mrw_fire;
    logic [2:0] mrw_sel;
    logic sre_fire;
    logic srx_fire;
    logic dll_rst_fire;
    logic [MR_W-1:0] mr [MR_COUNT];
    dllrf_sr_t state;
    logic [HOLD_W-1:0] hold_cnt;
    logic rate_in_sr;
    logic relock_pending;
    logic lock_run;
    logic [LOCK_W-1:0] lock_cnt;
    logic dll_locked;
    logic dll_en;
    logic lvl_active;
    logic qoff;
    logic [LANES-1:0] lane_fb;
    logic [31:0] next_rdata;
    logic next_err;

    ////////////////////////////////////////////////////////////////////////////////
    // Link clock synchroniser and rising edge detect
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ck_sync <= 2'h0;
            ck_q <= 1'b0;
        end else begin
            ck_sync <= {ck_sync[0], CK_IN};
            ck_q <= ck_sync[1];
        end
    end

    assign ck_rise = ck_sync[1] & ~ck_q;

    ////////////////////////////////////////////////////////////////////////////////
    // APB strobes and command decode
    assign access = PSEL_IN & PENABLE_IN & PREADY_OUT;
    assign wr_fire = access & PWRITE_IN;
    assign mrw_fire = wr_fire && (PADDR_IN == OFF_MRW);
    assign mrw_sel = PWDATA_IN[MR_SEL_LSB +: 3];
    assign sre_fire = wr_fire && (PADDR_IN == OFF_CMD) && PWDATA_IN[CMD_SRE_BIT] && (state == ST_IDLE);
    assign srx_fire = wr_fire && (PADDR_IN == OFF_CMD) && PWDATA_IN[CMD_SRX_BIT] && (state != ST_IDLE);
    assign dll_rst_fire = mrw_fire && (mrw_sel == MR_LATENCY) && PWDATA_IN[DLL_RST_BIT]
        && (state == ST_IDLE) && dll_en; // R13
    assign dll_en = mr[MR_DLL_TERM][DLL_EN_BIT]; // R22
    assign lvl_active = mr[MR_DLL_TERM][LVL_EN_BIT]; // R23
    assign qoff = mr[MR_DLL_TERM][QOFF_BIT];

    // One wait state; answer registered
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            PREADY_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
            PRDATA_OUT <= (PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~PWRITE_IN) ? next_rdata : 32'h0;
            PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & next_err;
        end
    end

    // Read mux and unmapped detection
    always_comb begin
        next_rdata = 32'h0;
        next_err = 1'b0;
        if (PADDR_IN == OFF_STATUS) begin
            next_rdata[ST_IN_SR_BIT] = (state != ST_IDLE);
            next_rdata[ST_CK_IGN_BIT] = (state == ST_SR_IGN);
            next_rdata[ST_DLL_EN_BIT] = dll_en;
            next_rdata[ST_LOCKED_BIT] = dll_locked;
            next_rdata[ST_LVL_BIT] = lvl_active;
            next_rdata[ST_PEND_BIT] = relock_pending;
        end else if (is_mr_addr(PADDR_IN)) begin
            next_rdata = {{(32-MR_W){1'b0}}, mr[mr_index(PADDR_IN)]};
        end else if (PADDR_IN == OFF_CMD || PADDR_IN == OFF_MRW) begin
            next_err = !PWRITE_IN;
        end else begin
            next_err = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode register file
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            for (int i = 0; i < MR_COUNT; i++) begin
                mr[i] <= MR_RESET;
            end
        end else if (mrw_fire && mrw_sel < 3'(MR_COUNT)) begin
            mr[mrw_sel] <= PWDATA_IN[MR_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self refresh: hold clock edges, then ignore the clock
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state <= ST_IDLE;
            hold_cnt <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    hold_cnt <= '0;
                    if (sre_fire) begin
                        state <= ST_SR_HOLD;
                    end
                end
                ST_SR_HOLD: begin
                    if (srx_fire) begin
                        state <= ST_IDLE;
                    end else if (ck_rise && hold_cnt == HOLD_W'(SRE_HOLD_NCK - 1)) begin
                        state <= ST_SR_IGN; // R2
                    end else if (ck_rise) begin
                        hold_cnt <= hold_cnt + HOLD_W'(1);
                    end
                end
                ST_SR_IGN: begin
                    if (srx_fire) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Data rate written during self refresh demands an explicit DLL reset
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rate_in_sr <= 1'b0;
            relock_pending <= 1'b0;
        end else begin
            if (mrw_fire && mrw_sel == MR_DATA_RATE && state != ST_IDLE) begin
                rate_in_sr <= 1'b1; // R13
            end else if (srx_fire) begin
                rate_in_sr <= 1'b0;
            end
            if (srx_fire && rate_in_sr) begin
                relock_pending <= 1'b1; // R13
            end else if (dll_rst_fire) begin
                relock_pending <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // DLL lock countdown on link clock edges
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            lock_run <= 1'b0;
            lock_cnt <= '0;
            dll_locked <= 1'b0;
        end else if (!dll_en || sre_fire) begin
            lock_run <= 1'b0; // R22
            lock_cnt <= '0;
            dll_locked <= 1'b0;
        end else if (dll_rst_fire || (srx_fire && !rate_in_sr)) begin
            lock_run <= 1'b1; // R13
            lock_cnt <= '0;
            dll_locked <= 1'b0;
        end else if (lock_run && ck_rise && state == ST_IDLE) begin
            if (lock_cnt == LOCK_W'(DLL_LOCK_NCK - 1)) begin
                lock_run <= 1'b0;
                dll_locked <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + LOCK_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write-leveling feedback, one lane per strobe
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        dllrf_lane u_lane (
            .clk_in(CLK_SYS_IN),
            .rstn_in(RSTN_IN),
            .ck_level_in(ck_sync[1]),
            .dqs_pin_in(DQS_IN[l]), // R20
            .fb_out(lane_fb[l])
        );
    end

    // Drive feedback on every bit of its lane, terminate strobes
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            DQ_OUT <= '0;
            DQ_OE_N_OUT <= '1;
            DQS_TERM_OUT <= 1'b0;
        end else begin
            for (int l = 0; l < LANES; l++) begin
                DQ_OUT[l*LANE_BITS +: LANE_BITS] <= lvl_active ? {LANE_BITS{lane_fb[l]}} : '0; // R19
                DQ_OE_N_OUT[l*LANE_BITS +: LANE_BITS] <= {LANE_BITS{~(lvl_active & ~qoff)}}; // R16
            end
            DQS_TERM_OUT <= lvl_active; // R18
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RSTN_IN);

    apb_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held longer than one cycle");
    clk_ignore_a: assert property ((state == ST_SR_HOLD && ck_rise && !srx_fire
        && hold_cnt == HOLD_W'(SRE_HOLD_NCK - 1)) |=> state == ST_SR_IGN) // R2
        else $error("clock not ignored after entry hold");
    ignore_stays_a: assert property ((state == ST_SR_IGN && !srx_fire) |=> state == ST_SR_IGN) // R2
        else $error("left clock-ignore without exit");
    auto_relock_a: assert property ((srx_fire && dll_en && !rate_in_sr) |=> lock_run && !dll_locked) // R13
        else $error("no automatic relock at exit");
    reset_needed_a: assert property ((srx_fire && dll_en && rate_in_sr) |=> relock_pending && !lock_run) // R13
        else $error("relock started without DLL reset");
    dll_off_a: assert property (!dll_en |=> !dll_locked && !lock_run) // R22
        else $error("DLL active while disabled");
    strobe_term_a: assert property (lvl_active |=> DQS_TERM_OUT) // R18
        else $error("strobe not terminated in leveling");
    all_bits_a: assert property ((lvl_active && !qoff) |=> DQ_OE_N_OUT == '0
        && DQ_OUT[LANE_BITS-1:0] == {LANE_BITS{$past(lane_fb[0])}}) // R19
        else $error("feedback missing on a data bit");
    lvl_exit_a: assert property (!lvl_active |=> DQ_OE_N_OUT == '1) // R23
        else $error("data driven outside leveling");

    sr_trip_c: cover property (state == ST_SR_IGN ##[1:1000] srx_fire);
    lock_done_c: cover property ($rose(dll_locked));
    fb_high_c: cover property (lvl_active && lane_fb[0]);

endmodule

`default_nettype wire

// ### tb/dllrf_ctrl_model.sv
// Controller-side model: link clock and one leveling strobe per lane.
// Assumes a free-running system clock; strobes launch on its rising edge.
`timescale 1ns/1ps
`default_nettype none

module dllrf_ctrl_model #(
    parameter int LANES = 2
) (
    input wire logic clk_in,
    input wire logic ck_run_in,
    output logic ck_out,
    output logic [LANES-1:0] dqs_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Link clock, 80 ns, held low while stopped in self refresh
    initial begin
        ck_out = 1'b0;
        dqs_out = '0;
        #3;
        forever begin
            #40;
            ck_out = ck_run_in ? ~ck_out : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One leveling strobe, d system cycles after a clock rise
    task automatic strobe(input int lane, input int d);
        @(posedge ck_out);
        @(posedge clk_in);
        repeat (d) @(posedge clk_in);
        dqs_out[lane] <= 1'b1;
        repeat (2) @(posedge clk_in);
        dqs_out[lane] <= 1'b0;
    endtask

endmodule

`default_nettype wire

// ### tb/dllrf_top_test.sv
// Self-checking bench for the DLL relock and write-leveling block.
// Assumes the controller model drives the link clock and strobes.
`timescale 1ns/1ps
`default_nettype none

module dllrf_top_test
    import dllrf_pkg::*;
;
    localparam int LOCK = 16;
    localparam int HOLD = 2;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ck_run = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ck;
    logic [1:0] dqs;
    logic [15:0] dq;
    logic [15:0] dq_oe_n;
    logic term;
    logic [32:0] exp_q[$];
    int fails = 0;
    int checks = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and controller model
    always #5 clk = ~clk;

    dllrf_top #(.DLL_LOCK_NCK(LOCK), .SRE_HOLD_NCK(HOLD)) u_dllrf_top (
        .CLK_SYS_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .CK_IN(ck), .DQS_IN(dqs), .DQ_OUT(dq), .DQ_OE_N_OUT(dq_oe_n),
        .DQS_TERM_OUT(term)
    );

    dllrf_ctrl_model u_dllrf_ctrl_model (.clk_in(clk), .ck_run_in(ck_run), .ck_out(ck), .dqs_out(dqs));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare tasks and verdict
    task automatic cmp_apb(input logic [32:0] e, input logic [32:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value apb data/err: expected %h, seen %h", e, g);
        end
    endtask

    task automatic cmp_pin(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic test_done;
        if (exp_q.size() != 0) fails++;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // APB master and helpers; every task ends just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {e, 1'b0});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic mrw(input logic [2:0] s, input logic [17:0] v);
        wr(OFF_MRW, {11'h0, s, v});
    endtask

    task automatic wait_ck(input int n);
        repeat (n) @(posedge ck);
        @(posedge clk);
    endtask

    task automatic pins(input logic [15:0] e_dq, input logic [15:0] e_oe, input logic e_t);
        cmp_pin("dq", e_dq, dq);
        cmp_pin("dq_oe_n", e_oe, dq_oe_n);
        cmp_pin("dqs_term", {15'h0, e_t}, {15'h0, term});
    endtask

    // Self refresh round trip with a stopped and restarted clock
    task automatic sr_cycle(input logic rate_wr);
        wr(OFF_CMD, 32'h1);
        rd(OFF_STATUS, 32'h5);
        wait_ck(HOLD + 2);
        rd(OFF_STATUS, 32'h7);
        ck_run <= 1'b0;
        repeat (20) @(posedge clk);
        if (rate_wr) mrw(MR_DATA_RATE, 18'h0000a);
        ck_run <= 1'b1;
        wait_ck(4);
        wr(OFF_CMD, 32'h2);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Result monitor: pops the oldest note at each ready
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) cmp_apb(33'h0, 33'h1ffffffff);
            else cmp_apb(exp_q.pop_front(), {prdata, pslverr});
        end
    end

    // Watchdog
    initial begin
        #100us;
        fails++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [17:0] v;
        int d;
        int ln[4] = '{0, 1, 1, 0};
        int dl[4] = '{1, 5, 1, 5};
        logic [15:0] ex[4] = '{16'h00ff, 16'h00ff, 16'hffff, 16'hff00};
        void'($urandom(32'ha9d0));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        ck_run <= 1'b1;
        pins(16'h0, 16'hffff, 1'b0);
        for (int i = 0; i < 7; i++) rd(OFF_MR_BASE + 8'(4 * i), 32'h0);
        apb(1'b0, 8'h40, 32'h0, 33'h1);
        apb(1'b0, OFF_CMD, 32'h0, 33'h1);
        apb(1'b1, 8'h44, 32'h5, 33'h1);
        wr(OFF_CMD, 32'h2);
        rd(OFF_STATUS, 32'h0);
        mrw(MR_DLL_TERM, 18'h00001);
        rd(OFF_STATUS, 32'h4);
        for (int i = 2; i < 6; i++) begin
            v = 18'($urandom);
            if (i == 5) v[2:0] = 3'h0;
            mrw(3'(i), v);
            rd(OFF_MR_BASE + 8'(4 * i), {14'h0, v});
        end
        mrw(MR_DATA_RATE, 18'h00005);
        sr_cycle(1'b0);
        wait_ck(12);
        rd(OFF_STATUS, 32'h4);
        wait_ck(LOCK - 10);
        rd(OFF_STATUS, 32'hc);
        sr_cycle(1'b1);
        wait_ck(LOCK + 2);
        rd(OFF_STATUS, 32'h24);
        mrw(MR_LATENCY, 18'h00100);
        wait_ck(LOCK + 2);
        rd(OFF_STATUS, 32'hc);
        rd(OFF_MR_BASE + 8'h18, 32'ha);
        mrw(3'h5, 18'h00003);
        mrw(MR_DLL_TERM, 18'h00081);
        repeat (2) @(posedge clk);
        pins(16'h0, 16'h0, 1'b1);
        rd(OFF_STATUS, 32'h1c);
        for (int k = 0; k < 4; k++) begin
            u_dllrf_ctrl_model.strobe(ln[k], dl[k]);
            repeat (6) @(posedge clk);
            cmp_pin("dq lanes", ex[k], dq);
        end
        d = 5;
        do begin
            u_dllrf_ctrl_model.strobe(0, d);
            repeat (6) @(posedge clk);
            d++;
        end while (dq[0] !== 1'b1 && d < 13);
        cmp_pin("leveled delay", 16'h1, 16'(d >= 8 && d <= 11));
        mrw(MR_DLL_TERM, 18'h00001);
        repeat (2) @(posedge clk);
        pins(16'h0, 16'hffff, 1'b0);
        rd(OFF_STATUS, 32'hc);
        test_done();
    end

endmodule

`default_nettype wire
